// ### shared/serial_lane_pkg.sv
`default_nettype none
package serial_lane_pkg;

    ////////////////////////////////////////////////////////////////////////
    // lane widths and commands
    typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;

    localparam logic [7:0] OP_ENTER_DUAL = 8'h3b;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_LANE_RESET = 8'hff;

    // lane steps per byte in each width
    localparam logic [3:0] STEPS_SINGLE = 4'h8;
    localparam logic [3:0] STEPS_DUAL = 4'h4;
    localparam logic [3:0] STEPS_QUAD = 4'h2;

    // lane masks: single mode uses data_lane0 host to client, data_lane1 back
    localparam logic [3:0] LANES_SINGLE_IN = 4'h1;
    localparam logic [3:0] LANES_SINGLE_OUT = 4'h2;
    localparam logic [3:0] LANES_DUAL = 4'h3;
    localparam logic [3:0] LANES_QUAD = 4'hf;
    localparam logic [3:0] PAUSE_LANE_MASK = 4'h8;
    localparam int PAUSE_LANE = 3;

    ////////////////////////////////////////////////////////////////////////
    // timing of the host-made link clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 60;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_GAP_CYC = SCLK_HALF_CYC;
    localparam logic [1:0] RECOVER_FRAMES = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // shared lane arithmetic
    function automatic logic [3:0] lane_steps(input lane_mode_t mode);
        case (mode)
            LANE_QUAD: lane_steps = STEPS_QUAD;
            LANE_DUAL: lane_steps = STEPS_DUAL;
            default: lane_steps = STEPS_SINGLE;
        endcase
    endfunction : lane_steps

    // msb first: the newest lanes enter at the bottom
    function automatic logic [7:0] shift_in(input lane_mode_t mode, input logic [7:0] sh,
                                            input logic [3:0] lanes, input logic bit_in);
        case (mode)
            LANE_QUAD: shift_in = {sh[3:0], lanes};
            LANE_DUAL: shift_in = {sh[5:0], lanes[1:0]};
            default: shift_in = {sh[6:0], bit_in};
        endcase
    endfunction : shift_in

    function automatic logic [3:0] lane_mask(input lane_mode_t mode, input logic [3:0] single);
        case (mode)
            LANE_QUAD: lane_mask = LANES_QUAD;
            LANE_DUAL: lane_mask = LANES_DUAL;
            default: lane_mask = single;
        endcase
    endfunction : lane_mask

    function automatic logic [3:0] lane_out(input lane_mode_t mode, input logic [7:0] sh,
                                            input logic [3:0] single);
        case (mode)
            LANE_QUAD: lane_out = sh[7:4];
            LANE_DUAL: lane_out = {2'b00, sh[7:6]};
            default: lane_out = single & {4{sh[7]}};
        endcase
    endfunction : lane_out

    // mode after a frame's first byte; entries only from single width
    function automatic lane_mode_t next_mode(input lane_mode_t mode, input logic [7:0] op);
        next_mode = mode;
        if (op == OP_LANE_RESET) begin
            next_mode = LANE_SINGLE;
        end else if (mode == LANE_SINGLE && op == OP_ENTER_DUAL) begin
            next_mode = LANE_DUAL;
        end else if (mode == LANE_SINGLE && op == OP_ENTER_QUAD) begin
            next_mode = LANE_QUAD;
        end
    endfunction : next_mode

endpackage : serial_lane_pkg
`default_nettype wire

// ### shared/serial_lane_if.sv
`timescale 1ns/100ps
`default_nettype none
interface serial_lane_if;
    logic cs_n;
    logic sclk;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] d_out;
    logic [3:0] d_oe;
    logic [3:0] lane;

    // wired lanes: host wins a clash, an undriven lane floats high on its pull-up
    assign lane = (h_oe & h_out) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe);

    modport host (output cs_n, output sclk, output h_out, output h_oe, input lane);
    modport client (input cs_n, input sclk, input lane, output d_out, output d_oe);
endinterface : serial_lane_if
`default_nettype wire

// ### hw/pair_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,          // buffer clock
    input wire logic rst_n_i,        // async reset, active low
    input wire logic in_valid_i,     // word offered
    input wire logic [W-1:0] in_data_i, // offered word
    output logic in_ready_o,         // room for a word
    output logic out_valid_o,        // word waiting
    output logic [W-1:0] out_data_o, // oldest word
    input wire logic out_ready_i     // drain takes the word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pointers wrap freely, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("pair_buffer depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } buf_t;

    buf_t buf_reg, buf_next;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // honest full and empty straight from the count
    assign in_ready_o = buf_reg.cnt != (AW + 1)'(DEPTH);
    assign out_valid_o = buf_reg.cnt != '0;
    assign out_data_o = buf_reg.mem[buf_reg.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // next state
    always_comb begin
        buf_next = buf_reg;
        if (push) begin
            buf_next.mem[buf_reg.wr] = in_data_i;
            buf_next.wr = buf_reg.wr + 1'b1;
        end
        if (pop) begin
            buf_next.rd = buf_reg.rd + 1'b1;
        end
        buf_next.cnt = buf_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_reg <= '0;
        end else begin
            buf_reg <= buf_next;
        end
    end
endmodule : pair_buffer
`default_nettype wire

// ### hw/lane_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module lane_host_end
    import serial_lane_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYC, // system cycles per link clock phase
    parameter int RX_DEPTH = 2               // receive buffer entries
) (
    input wire logic CLOCK_I,            // system clock, 100 MHz
    input wire logic RESETN_I,           // async reset, active low
    serial_lane_if.host link,            // lanes, select, link clock out
    input wire logic REQ_VALID_I,        // frame request offered
    output logic REQ_READY_O,            // frame request taken
    input wire logic [7:0] REQ_WR_LEN_I, // bytes sent, opcode included
    input wire logic [7:0] REQ_RD_LEN_I, // bytes read after them
    input wire logic [7:0] TX_DATA_I,    // byte to send
    input wire logic TX_VALID_I,         // byte offered
    output logic TX_READY_O,             // byte taken
    output logic [7:0] RX_DATA_O,        // byte read back
    output logic RX_VALID_O,             // read byte waiting
    input wire logic RX_READY_I,         // user takes read byte
    input wire logic PAUSE_I,            // user asks for a pause
    output logic PAUSED_O,               // pause line held low
    output logic BUSY_O,                 // frame or recovery running
    output var lane_mode_t MODE_O        // width the host believes in
);
    if (SCLK_HALF < 1 || SCLK_HALF > 255) begin : g_half_check
        $error("lane_host_end SCLK_HALF must lie in 1..255");
    end

    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [7:0] cnt;
        logic sclk;
        logic cs_n;
        logic pause_n;
        lane_mode_t mode;
        logic [7:0] wr_left;
        logic [7:0] rd_left;
        logic [7:0] sh;
        logic [7:0] op;
        logic [3:0] step;
        logic first;
        logic loaded;
        logic reading;
        logic internal;
        logic [1:0] rec;
        logic push;
        logic [7:0] rx;
    } host_t;

    localparam host_t HOST_RESET = '{st: H_IDLE, cs_n: 1'b1, pause_n: 1'b1, mode: LANE_SINGLE,
                                     rec: RECOVER_FRAMES, default: '0};
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
    localparam logic [7:0] GAP_LAST = 8'(CS_GAP_CYC - 1);

    host_t s, n;
    logic take_tx, fifo_ready, writing;

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer: the link clock is this state's sclk field
    always_comb begin
        n = s;
        n.push = 1'b0;
        take_tx = 1'b0;
        case (s.st)
            H_IDLE: begin
                n.cnt = 8'h00;
                n.step = 4'h0;
                n.first = 1'b1;
                n.loaded = 1'b0;
                if (s.rec != 2'h0) begin
                    // blind exit: lane reset in quad width, then in dual
                    n.st = H_LOW;
                    n.cs_n = 1'b0;
                    n.internal = 1'b1;
                    n.wr_left = 8'h01;
                    n.rd_left = 8'h00;
                    n.mode = (s.rec == RECOVER_FRAMES) ? LANE_QUAD : LANE_DUAL;
                end else if (REQ_VALID_I) begin
                    n.st = H_LOW;
                    n.cs_n = 1'b0;
                    n.internal = 1'b0;
                    n.wr_left = REQ_WR_LEN_I;
                    n.rd_left = REQ_RD_LEN_I;
                end
            end
            H_LOW: begin
                // pause only mid-byte and never in quad width
                n.pause_n = !(PAUSE_I && s.mode != LANE_QUAD && s.loaded);
                if (!s.loaded) begin
                    if (s.wr_left != 8'h00) begin
                        if (s.internal) begin
                            n.sh = OP_LANE_RESET;
                            n.op = OP_LANE_RESET;
                            n.loaded = 1'b1;
                            n.reading = 1'b0;
                        end else if (TX_VALID_I) begin
                            take_tx = 1'b1;
                            n.sh = TX_DATA_I;
                            n.op = s.first ? TX_DATA_I : s.op;
                            n.loaded = 1'b1;
                            n.reading = 1'b0;
                        end
                    end else if (s.rd_left != 8'h00) begin
                        // a pending push has not reached the count yet, so wait it out
                        if (fifo_ready && !s.push) begin
                            n.loaded = 1'b1;
                            n.reading = 1'b1;
                        end
                    end else begin
                        // select rises only with the pause released
                        n.st = H_GAP;
                        n.cs_n = 1'b1;
                        n.cnt = 8'h00;
                    end
                end else if (s.pause_n && n.pause_n) begin
                    // release seen while low resumes at once
                    if (s.cnt == HALF_LAST) begin
                        n.cnt = 8'h00;
                        n.sclk = 1'b1;
                        n.st = H_HIGH;
                        if (s.reading) begin
                            n.sh = shift_in(s.mode, s.sh, link.lane, link.lane[1]);
                        end
                    end else begin
                        n.cnt = s.cnt + 8'h01;
                    end
                end
            end
            H_HIGH: begin
                if (s.cnt == HALF_LAST) begin
                    n.cnt = 8'h00;
                    n.sclk = 1'b0;
                    n.st = H_LOW;
                    if (!s.reading) begin
                        n.sh = shift_in(s.mode, s.sh, 4'h0, 1'b0);
                    end
                    if (s.step == lane_steps(s.mode) - 4'h1) begin
                        n.step = 4'h0;
                        n.loaded = 1'b0;
                        n.first = 1'b0;
                        if (s.reading) begin
                            n.rd_left = s.rd_left - 8'h01;
                            n.push = 1'b1;
                            n.rx = s.sh;
                        end else begin
                            n.wr_left = s.wr_left - 8'h01;
                        end
                        if (s.first && !s.reading) begin
                            // track the width the client switches to
                            n.mode = next_mode(s.mode, s.op);
                        end
                    end else begin
                        n.step = s.step + 4'h1;
                    end
                end else begin
                    n.cnt = s.cnt + 8'h01;
                end
            end
            H_GAP: begin
                if (s.cnt == GAP_LAST) begin
                    n.st = H_IDLE;
                    if (s.internal) begin
                        n.rec = s.rec - 2'h1;
                    end
                end else begin
                    n.cnt = s.cnt + 8'h01;
                end
            end
            default: begin
                n = HOST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s <= HOST_RESET;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: the pause line stays driven outside quad width, high unless pausing
    assign writing = !s.cs_n && s.loaded && !s.reading;
    assign link.cs_n = s.cs_n;
    assign link.sclk = s.sclk;
    assign link.h_oe = (writing ? lane_mask(s.mode, LANES_SINGLE_IN) : 4'h0)
                     | ((s.mode != LANE_QUAD) ? PAUSE_LANE_MASK : 4'h0);
    assign link.h_out = (s.mode != LANE_QUAD)
                      ? {s.pause_n, 3'(lane_out(s.mode, s.sh, LANES_SINGLE_IN))}
                      : lane_out(s.mode, s.sh, LANES_SINGLE_IN);

    // read bytes wait in this buffer; a full buffer stalls the link clock
    pair_buffer #(.W(8), .DEPTH(RX_DEPTH)) rx_buffer (
        .clk_i(CLOCK_I),
        .rst_n_i(RESETN_I),
        .in_valid_i(s.push),
        .in_data_i(s.rx),
        .in_ready_o(fifo_ready),
        .out_valid_o(RX_VALID_O),
        .out_data_o(RX_DATA_O),
        .out_ready_i(RX_READY_I)
    );

    assign REQ_READY_O = (s.st == H_IDLE) && (s.rec == 2'h0);
    assign TX_READY_O = take_tx;
    assign PAUSED_O = !s.pause_n;
    assign BUSY_O = (s.st != H_IDLE) || (s.rec != 2'h0);
    assign MODE_O = s.mode;
endmodule : lane_host_end
`default_nettype wire

// ### hw/lane_client_end.sv
// Operation
// - host holds pause line high unless pausing
// - pause freezes the sequence without resetting it
// - pause acts now if clock low
// - host keeps select low while paused
// - paused client ignores data and clock
// - release acts now if clock low
// - output floats and returns with pause line
// - no pause in quad width
// - dual width moves two bits, msb first
// - quad width moves one nibble, msb first
// - enter-dual command selects dual width
// - enter-quad command selects quad width
// - lane reset is sent in current width
// - host recovers an unknown width after reset
// - enter-dual opcode is 3b
// - enter-quad opcode is 38
// - lane reset opcode ff selects single width
`timescale 1ns/100ps
`default_nettype none
module lane_client_end
    import serial_lane_pkg::*;
(
    serial_lane_if.client link,      // lanes, select and the link clock
    input wire logic RESETN_I,       // power-on reset, active low
    input wire logic [7:0] TX_BYTE_I, // next byte to send, link clock domain
    input wire logic TURN_I,         // multi-lane: client may drive the lanes
    output logic [7:0] RX_BYTE_O,    // last byte taken in
    output logic RX_VALID_O,         // one link clock per byte
    output var lane_mode_t MODE_O,   // current lane width
    output logic PAUSED_O            // transfer frozen by the pause line
);

    ////////////////////////////////////////////////////////////////////////
    // state
    // frame state lives only while selected; the width lives across frames
    typedef struct packed {
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic [3:0] step;
        logic first;
        logic drive;
        logic [7:0] rx_byte;
        logic rx_valid;
    } frame_t;

    localparam frame_t FRAME_RESET = '{first: 1'b1, default: '0};

    frame_t frame_reg, frame_next;
    lane_mode_t mode_reg, mode_next;
    logic frame_rst_n;
    logic pause_ok;
    logic byte_done;
    logic [7:0] byte_in;
    logic drive_en;

    ////////////////////////////////////////////////////////////////////////
    // select and pause
    // deselect clears the sequence at once; the link clock may have stopped,
    // so no edge can be counted on to do it
    assign frame_rst_n = RESETN_I & ~link.cs_n;

    // the pause line is read at the rising edge itself: a pause raised in the
    // low phase blocks that edge, one raised in the high phase only blocks the
    // next rising edge, which is the same as acting at the falling edge
    // in quad width the pause lane carries data, so it never freezes
    assign pause_ok = (mode_reg == LANE_QUAD) | link.lane[PAUSE_LANE];

    ////////////////////////////////////////////////////////////////////////
    // byte assembly
    // the lanes enter msb first in the width that is current
    assign byte_in = shift_in(mode_reg, frame_reg.rx_sh, link.lane, link.lane[0]);
    assign byte_done = frame_reg.step == lane_steps(mode_reg) - 4'h1;

    // next frame and width state
    always_comb begin
        frame_next = frame_reg;
        frame_next.rx_valid = 1'b0;
        mode_next = mode_reg;
        if (pause_ok) begin
            // a frozen edge changes nothing, so the byte resumes where it stood
            frame_next.rx_sh = byte_in;
            frame_next.tx_sh = shift_in(mode_reg, frame_reg.tx_sh, 4'h0, 1'b0);
            if (byte_done) begin
                frame_next.step = 4'h0;
                frame_next.first = 1'b0;
                frame_next.rx_byte = byte_in;
                frame_next.rx_valid = 1'b1;
                frame_next.tx_sh = TX_BYTE_I;
                frame_next.drive = 1'b1;
                if (frame_reg.first) begin
                    // commands are decoded in the width they arrived
                    mode_next = next_mode(mode_reg, byte_in);
                    if (byte_in == OP_ENTER_DUAL || byte_in == OP_ENTER_QUAD ||
                        byte_in == OP_LANE_RESET) begin
                        // a width command ends the useful part of the frame
                        frame_next.drive = 1'b0;
                    end
                end
            end else begin
                frame_next.step = frame_reg.step + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers on the link clock
    // frame state: cleared by power-on reset and by deselect
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            frame_reg <= FRAME_RESET;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // width: power-on reset only, so deselect keeps it
    always_ff @(posedge link.sclk or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode_reg <= LANE_SINGLE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output lanes
    // single width answers on data_lane1 once an opcode other than a width command is in; in
    // dual and quad width the lanes are shared, so the user must hand over
    // the turn, or both ends would fight over them
    // the pause line gates the enable without any clock, so the output
    // floats the moment it falls and returns the moment it rises
    assign drive_en = frame_reg.drive & ~link.cs_n & pause_ok
                    & ((mode_reg == LANE_SINGLE) | TURN_I);

    // data comes from the shift register, msb first
    assign link.d_out = lane_out(mode_reg, frame_reg.tx_sh, LANES_SINGLE_OUT);
    assign link.d_oe = drive_en ? lane_mask(mode_reg, LANES_SINGLE_OUT) : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // user side, all in the link clock domain
    // the byte pulse lasts until the next link clock edge or deselect,
    // whichever comes first; a stopped clock stretches it
    assign RX_BYTE_O = frame_reg.rx_byte;
    assign RX_VALID_O = frame_reg.rx_valid;
    assign MODE_O = mode_reg;
    // pause shown only while it can really freeze a selected frame
    assign PAUSED_O = ~link.cs_n & ~pause_ok;

    // width reference for the next edge: the same function both ends use
    // keeps the two in step byte for byte, so no extra handshake is needed
    // to agree on where a byte ends

endmodule : lane_client_end
`default_nettype wire

// ### verif/serial_lane_chk.sv
`timescale 1ns/100ps
`default_nettype none
module serial_lane_chk (
    input wire logic CLOCK_I, // sys clock
    input wire logic RESETN_I, // reset, low
    input wire logic cs_n, // select, low
    input wire logic sclk, // link clock
    input wire logic [3:0] h_out, // host data
    input wire logic [3:0] h_oe, // host enables
    input wire logic [3:0] d_out, // client data
    input wire logic [3:0] d_oe, // client enables
    input wire logic [3:0] lane // wired lanes
);
    // pause line pulled low by the host; an idle lane2 rules out quad data on lane3
    wire logic pz = !cs_n && h_oe[3] && !h_out[3] && !h_oe[2];
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    property p_float; pz |-> d_oe[1:0] == 2'h0; endproperty
    a_float: assert property (p_float) else $error("lane driven in pause");
    property p_frozen; pz && $past(pz) |-> $stable(d_out); endproperty
    a_frozen: assert property (p_frozen) else $error("client moved in pause");
    property p_enter; $rose(pz) |-> !sclk; endproperty
    a_enter: assert property (p_enter) else $error("pause taken on high clock");
    property p_leave; $fell(pz) && !cs_n |-> !sclk; endproperty
    a_leave: assert property (p_leave) else $error("release on high clock");
    property p_sel; pz |=> !cs_n; endproperty
    a_sel: assert property (p_sel) else $error("deselect in pause");
    property p_idle; cs_n |-> lane[3]; endproperty
    a_idle: assert property (p_idle) else $error("pause line low idle");
    property p_dual; d_oe[0] |-> d_oe[1]; endproperty
    a_dual: assert property (p_dual) else $error("lane pair split");
    property p_quad; d_oe[2] |-> d_oe == 4'hf; endproperty
    a_quad: assert property (p_quad) else $error("nibble split");
    c_pause: cover property (pz);
    c_dual: cover property (d_oe == 4'h3);
    c_quad: cover property (d_oe == 4'hf);
endmodule : serial_lane_chk
`default_nettype wire

// ### verif/serial_sram_pause_and_multilane_io_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_sram_pause_and_multilane_io_bench import serial_lane_pkg::*;;
    logic clk = 0, rst_n = 0, rq_v = 0, tx_v = 1, rx_r = 1, pause = 0, turn = 0, h_rn = 1;
    logic rq_r, tx_r, rx_v, h_p, busy, c_rv, c_p;
    logic [7:0] nw = 0, nr = 0, txi = 0, tx_b = 8'hc3, rx_d, c_rb;
    logic [7:0] wb [8] = '{default: 8'h00};
    logic [7:0] rxq [$], crx [$];
    lane_mode_t h_m, c_m;
    int error_cnt = 0, samples_checked = 0;
    always #5 clk = ~clk;
    serial_lane_if lk();
    lane_host_end #(.SCLK_HALF(2)) u_lane_host_end (.CLOCK_I(clk), .RESETN_I(rst_n & h_rn),
        .link(lk),
        .REQ_VALID_I(rq_v), .REQ_READY_O(rq_r), .REQ_WR_LEN_I(nw), .REQ_RD_LEN_I(nr),
        .TX_DATA_I(wb[txi[2:0]]), .TX_VALID_I(tx_v), .TX_READY_O(tx_r), .RX_DATA_O(rx_d),
        .RX_VALID_O(rx_v), .RX_READY_I(rx_r), .PAUSE_I(pause), .PAUSED_O(h_p), .BUSY_O(busy),
        .MODE_O(h_m));
    lane_client_end u_lane_client_end (.link(lk), .RESETN_I(rst_n), .TX_BYTE_I(tx_b), .TURN_I(turn),
        .RX_BYTE_O(c_rb), .RX_VALID_O(c_rv), .MODE_O(c_m), .PAUSED_O(c_p));
    serial_lane_chk u_serial_lane_chk (.CLOCK_I(clk), .RESETN_I(rst_n), .cs_n(lk.cs_n),
        .sclk(lk.sclk), .h_out(lk.h_out), .h_oe(lk.h_oe), .d_out(lk.d_out), .d_oe(lk.d_oe),
        .lane(lk.lane));
    // byte feed on the host user side, capture on both user sides
    always @(posedge clk) begin
        if (tx_r && tx_v) txi <= txi + 8'h01;
        if (rx_v && rx_r) rxq.push_back(rx_d);
    end
    always @(negedge lk.sclk) if (c_rv) crx.push_back(c_rb);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one frame: request held until taken, then bounded wait for idle
    task automatic frame(input logic [7:0] w, input logic [7:0] r);
        int i = 0;
        nw = w;
        nr = r;
        txi = 0;
        rxq = {};
        crx = {};
        rq_v = 1;
        while (rq_r !== 1'b1 && i < 4000) begin tick(1); i++; end
        tick(1);
        rq_v = 0;
        while (busy !== 1'b0 && i < 8000) begin tick(1); i++; end
        if (i >= 8000) begin error_cnt++; report_and_stop(); end
    endtask : frame
    // write with a pause inside, then a read stalled by a full buffer
    task automatic xfer(input lane_mode_t m);
        wb = '{8'h02, 8'ha5, 8'h3c, 8'h96, 8'h0f, 8'h00, 8'h00, 8'h00};
        fork
            frame(8'h05, 8'h00);
            begin
                tick(16);
                pause = 1;
                tick(40);
                chk("client paused", {7'h0, m != LANE_QUAD}, {7'h0, c_p});
                chk("host paused", {7'h0, m != LANE_QUAD}, {7'h0, h_p});
                pause = 0;
            end
        join
        chk("client count", 8'h05, 8'(crx.size()));
        for (int k = 0; k < 5; k++) chk("client byte", wb[k], crx[k]);
        wb[0] = 8'h03;
        turn = 1;
        rx_r = 0;
        fork
            frame(8'h01, 8'h03);
            begin
                tick(40);
                pause = 1;
                tick(20);
                chk("lane float", (m == LANE_QUAD) ? 8'h0f : 8'h00, {4'h0, lk.d_oe});
                pause = 0;
                tick(240);
                chk("rx waiting", 8'h01, {7'h0, rx_v});
                chk("link stalled", 8'h01, {7'h0, busy});
                rx_r = 1;
            end
        join
        turn = 0;
        chk("host count", 8'h03, 8'(rxq.size()));
        for (int k = 0; k < 3; k++) chk("host byte", tx_b, rxq[k]);
    endtask : xfer
    // enter a width, use it, leave by lane reset
    task automatic width(input logic [7:0] op, input lane_mode_t m, input string n);
        wb[0] = op;
        frame(8'h01, 8'h00);
        chk("host width", {6'h0, m}, {6'h0, h_m});
        xfer(m);
        chk("client width", {6'h0, m}, {6'h0, c_m});
        wb[0] = 8'hff;
        frame(8'h01, 8'h00);
        chk("host single", {6'h0, LANE_SINGLE}, {6'h0, h_m});
        chk("client single", {6'h0, LANE_SINGLE}, {6'h0, c_m});
        $display("test %s done", n);
    endtask : width
    // host restarts alone, client left in quad
    task automatic restart;
        wb[0] = 8'h38;
        frame(8'h01, 8'h00);
        chk("client quad", {6'h0, LANE_QUAD}, {6'h0, c_m});
        h_rn = 0;
        tick(4);
        h_rn = 1;
        frame(8'h00, 8'h00);
        chk("client recovered", {6'h0, LANE_SINGLE}, {6'h0, c_m});
        $display("test restart done");
    endtask : restart
    initial begin
        tick(4);
        rst_n = 1;
        frame(8'h00, 8'h00);
        xfer(LANE_SINGLE);
        chk("client start", {6'h0, LANE_SINGLE}, {6'h0, c_m});
        $display("test single done");
        width(8'h3b, LANE_DUAL, "dual");
        width(8'h38, LANE_QUAD, "quad");
        restart();
        report_and_stop();
    end
endmodule : serial_sram_pause_and_multilane_io_bench
`default_nettype wire
